// file: lie_executor.sv
// Ladder executor: one instruction per cycle, element memories, timers,
// counters and master-control nesting.
// Assumes the fetch side presents the instruction at prog_addr each cycle
// that instr_valid is high, and that x_in is synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "lie_defines.svh"
module lie_executor
	import lie_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `LIE_TICK_MS * `LIE_CLK_KHZ
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire lie_op_t instr_op,
	input wire lie_kind_t instr_kind,
	input wire logic [9:0] instr_index,
	input wire logic [15:0] instr_k,
	input wire logic instr_pre_d,
	input wire logic [8:0] instr_pre_idx,
	input wire logic [2:0] instr_level,
	input wire logic [`LIE_X_N-1:0] x_in,
	input wire logic dw_en,
	input wire logic [8:0] dw_idx,
	input wire logic [15:0] dw_data,
	output logic [`LIE_ADDR_W-1:0] prog_addr,
	output logic acc,
	output logic [`LIE_Y_N-1:0] y_out,
	output logic app_fire,
	output logic scan_done,
	output logic err
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [`LIE_ADDR_W-1:0] addr_q;
	logic acc_q, saved_q, app_q, done_q, err_q, tick_q;
	logic [31:0] div_q;
	logic [`LIE_Y_N-1:0] y_q;
	logic [`LIE_M_N-1:0] m_q;
	logic [15:0] t_val_q [`LIE_T_N];
	logic [`LIE_T_N-1:0] t_coil_q, t_done_q, t_pend_q;
	logic [15:0] c_val_q [`LIE_C_N];
	logic [`LIE_C_N-1:0] c_coil_q, c_done_q, c_prev_q;
	logic [15:0] d_mem_q [`LIE_D_N];
	logic [`LIE_MC_LEVELS-1:0] mc_act_q, mc_cond_q;
	logic [3:0] mc_depth_q;

	logic gate, drive, contact, idx_bad, stk_dout, stk_err, mc_err;
	logic [15:0] preset, t_next, c_next;
	logic [7:0] ti;
	logic [6:0] ci;
	logic [3:0] yi;

	assign prog_addr = addr_q;
	assign acc = acc_q;
	assign y_out = y_q;
	assign app_fire = app_q;
	assign scan_done = done_q;
	assign err = err_q;

	assign ti = instr_index[7:0];
	assign ci = instr_index[6:0];
	assign yi = instr_index[3:0];
	// Open levels gate everything; closed levels are transparent
	assign gate = &(mc_cond_q | ~mc_act_q); // RL13
	assign drive = acc_q && gate;
	assign preset = instr_pre_d ? d_mem_q[instr_pre_idx] : instr_k; // RL8

	// ----------------------------------------
	// Operand decode
	// ----------------------------------------
	always_comb
	begin
		contact = 1'b0;
		idx_bad = 1'b0;
		unique case (instr_kind)
			LIE_K_X:
			begin
				idx_bad = instr_index >= 10'(`LIE_X_N);
				contact = x_in[yi];
			end
			LIE_K_Y:
			begin
				idx_bad = instr_index >= 10'(`LIE_Y_N);
				contact = y_q[yi];
			end
			LIE_K_M:
			begin
				idx_bad = instr_index >= 10'(`LIE_M_N);
				contact = idx_bad ? 1'b0 : m_q[instr_index];
			end
			LIE_K_T:
			begin
				idx_bad = instr_index >= 10'(`LIE_T_N);
				contact = idx_bad ? 1'b0 : t_done_q[ti];
			end
			LIE_K_C:
			begin
				idx_bad = instr_index >= 10'(`LIE_C_N);
				contact = idx_bad ? 1'b0 : c_done_q[ci];
			end
			LIE_K_D:
				idx_bad = instr_index >= 10'(`LIE_D_N);
			default:
				idx_bad = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Scan sequencing and time base
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			addr_q <= '0;
		else if (instr_valid)
			addr_q <= (instr_op == LIE_OP_END) ? '0 : addr_q + 1'b1; // RL20
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			done_q <= 1'b0;
		else
			done_q <= instr_valid && instr_op == LIE_OP_END;
	end

	// Timers only advance when their instruction runs, so ticks wait in t_pend_q
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			div_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= (div_q == TICK_CYCLES - 1);
			div_q <= (div_q == TICK_CYCLES - 1) ? '0 : div_q + 1;
		end
	end

	// ----------------------------------------
	// Accumulator and stack
	// ----------------------------------------
	lie_acc_stack u_stack (
		.clk(clk),
		.rst(rst),
		.push(instr_valid && instr_op == LIE_OP_PUSH),
		.peek(instr_valid && instr_op == LIE_OP_PEEK),
		.pop(instr_valid && instr_op == LIE_OP_POP),
		.din(acc_q),
		.dout(stk_dout),
		.err(stk_err)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			acc_q <= 1'b0;
			saved_q <= 1'b0;
		end
		else if (instr_valid)
		begin
			unique case (instr_op)
				LIE_OP_LOAD, LIE_OP_LOAD_INV:
				begin
					saved_q <= acc_q; // RL21
					acc_q <= contact ^ (instr_op == LIE_OP_LOAD_INV); // RL21
				end
				LIE_OP_PEEK, LIE_OP_POP:
					acc_q <= stk_dout; // RL2
				LIE_OP_END:
					acc_q <= 1'b0;
				default:
					acc_q <= acc_q;
			endcase
		end
	end

	// ----------------------------------------
	// Outputs and relays
	// ----------------------------------------
	// Out follows the gated rung; set and clear only act when driven
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			y_q <= '0;
			m_q <= '0;
		end
		else if (instr_valid && !idx_bad && (instr_kind == LIE_K_Y || instr_kind == LIE_K_M))
		begin
			if (instr_op == LIE_OP_OUT)
			begin
				if (instr_kind == LIE_K_Y)
					y_q[yi] <= drive; // RL16
				else
					m_q[instr_index] <= drive; // RL16
			end
			else if ((instr_op == LIE_OP_SET || instr_op == LIE_OP_RST) && drive) // RL17
			begin
				if (instr_kind == LIE_K_Y)
					y_q[yi] <= instr_op == LIE_OP_SET; // RL3 RL4
				else
					m_q[instr_index] <= instr_op == LIE_OP_SET; // RL3 RL4
			end
		end
	end

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	assign t_next = (t_pend_q[ti] && t_val_q[ti] != `LIE_KMAX) ? t_val_q[ti] + 16'h0001 : t_val_q[ti];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			t_pend_q <= '0;
		else if (tick_q)
			t_pend_q <= '1;
		else if (instr_valid && instr_op == LIE_OP_TMR && instr_kind == LIE_K_T && !idx_bad)
			t_pend_q[ti] <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			t_coil_q <= '0;
			t_done_q <= '0;
			for (int i = 0; i < `LIE_T_N; i++)
				t_val_q[i] <= 16'h0000;
		end
		else if (instr_valid && !idx_bad && instr_kind == LIE_K_T)
		begin
			if ((instr_op == LIE_OP_RST && drive) || (instr_op == LIE_OP_TMR && !gate))
			begin
				t_val_q[ti] <= 16'h0000; // RL5 RL14
				t_coil_q[ti] <= 1'b0;
				t_done_q[ti] <= 1'b0;
			end
			else if (instr_op == LIE_OP_TMR)
			begin
				t_coil_q[ti] <= acc_q; // RL8
				if (acc_q)
				begin
					t_val_q[ti] <= t_next; // RL8
					t_done_q[ti] <= t_done_q[ti] || t_next >= preset; // RL9 RL7
				end
			end
		end
	end

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	assign c_next = c_val_q[ci] + 16'h0001;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			c_coil_q <= '0;
			c_done_q <= '0;
			c_prev_q <= '0;
			for (int i = 0; i < `LIE_C_N; i++)
				c_val_q[i] <= 16'h0000;
		end
		else if (instr_valid && !idx_bad && instr_kind == LIE_K_C)
		begin
			if (instr_op == LIE_OP_RST && drive)
			begin
				c_val_q[ci] <= 16'h0000; // RL5
				c_coil_q[ci] <= 1'b0;
				c_done_q[ci] <= 1'b0;
				c_prev_q[ci] <= 1'b0;
			end
			else if (instr_op == LIE_OP_CNT)
			begin
				c_coil_q[ci] <= drive; // RL15
				c_prev_q[ci] <= drive;
				// Done counters skip this, so count and contact freeze; control off holds both
				if (!c_done_q[ci] && gate) // RL12 RL15
				begin
					// A preset already met, zero included, closes the contact without a count
					if (c_val_q[ci] == preset)
						c_done_q[ci] <= 1'b1; // RL11
					else if (drive && !c_prev_q[ci] && c_val_q[ci] < preset)
					begin
						c_val_q[ci] <= c_next; // RL10
						c_done_q[ci] <= c_next == preset; // RL11
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Data words
	// ----------------------------------------
	// Clear beats a same-cycle write from the application side
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < `LIE_D_N; i++)
				d_mem_q[i] <= 16'h0000;
		end
		else if (instr_valid && instr_op == LIE_OP_RST && instr_kind == LIE_K_D && !idx_bad && drive)
			d_mem_q[instr_index[8:0]] <= 16'h0000; // RL6
		else if (dw_en && dw_idx < 9'(`LIE_D_N))
			d_mem_q[dw_idx] <= dw_data;
	end

	// ----------------------------------------
	// Master control nesting
	// ----------------------------------------
	assign mc_err = instr_valid && instr_op == LIE_OP_MC && 4'(instr_level) != mc_depth_q; // RL19 RL22

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mc_act_q <= '0;
			mc_cond_q <= '0;
			mc_depth_q <= 4'h0;
		end
		else if (instr_valid)
		begin
			if (instr_op == LIE_OP_END)
			begin
				mc_act_q <= '0;
				mc_cond_q <= '0;
				mc_depth_q <= 4'h0;
			end
			else if (instr_op == LIE_OP_MC && !mc_err)
			begin
				mc_act_q[instr_level] <= 1'b1; // RL19
				mc_cond_q[instr_level] <= acc_q;
				mc_depth_q <= mc_depth_q + 4'h1;
			end
			else if (instr_op == LIE_OP_MCR && 4'(instr_level) < mc_depth_q)
			begin
				for (int i = 0; i < `LIE_MC_LEVELS; i++)
					if (i >= int'(instr_level))
					begin
						mc_act_q[i] <= 1'b0; // RL19
						mc_cond_q[i] <= 1'b0;
					end
				mc_depth_q <= 4'(instr_level);
			end
		end
	end

	// ----------------------------------------
	// Application trigger and errors
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			app_q <= 1'b0;
		else
			app_q <= instr_valid && instr_op == LIE_OP_APP && drive; // RL16
	end

	// Set aimed at anything but an output or relay is refused
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			err_q <= 1'b0;
		else
			err_q <= stk_err || mc_err || (instr_valid && idx_bad && instr_op != LIE_OP_NOP) ||
				(instr_valid && instr_op == LIE_OP_SET && instr_kind != LIE_K_Y && instr_kind != LIE_K_M); // RL22 RL3
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_peek_loads: // RL2
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_PEEK |=> acc_q == $past(stk_dout))
		else $error("peek did not load accumulator");
	a_set_latch: // RL3
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_SET && instr_kind == LIE_K_Y && !idx_bad && drive |=> y_q[$past(yi)])
		else $error("set did not turn output on");
	a_out_gated: // RL16
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_OUT && instr_kind == LIE_K_Y && !idx_bad && !gate |=> !y_q[$past(yi)])
		else $error("output energised with control off");
	a_end_wraps: // RL20
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_END |=> addr_q == '0 && done_q)
		else $error("end did not restart scan");
	a_cnt_frozen: // RL12
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_CNT && !idx_bad && instr_kind == LIE_K_C && c_done_q[ci]
		|=> c_val_q[$past(ci)] == $past(c_val_q[ci]) && c_done_q[$past(ci)])
		else $error("reached counter changed");
	a_tmr_mc_off: // RL14
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_TMR && instr_kind == LIE_K_T && !idx_bad && !gate
		|=> t_val_q[$past(ti)] == 16'h0000 && !t_coil_q[$past(ti)] && !t_done_q[$past(ti)])
		else $error("timer not reset under control off");
	a_rst_data: // RL6
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_RST && instr_kind == LIE_K_D && !idx_bad && drive
		|=> d_mem_q[$past(instr_index[8:0])] == 16'h0000)
		else $error("data word not cleared");
	a_mc_depth: // RL22
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_MC && mc_depth_q == 4'(`LIE_MC_LEVELS) |=> err_q ##1 !err_q[*1])
		else $error("nesting overflow not flagged");
	a_load_saves: // RL21
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && (instr_op == LIE_OP_LOAD || instr_op == LIE_OP_LOAD_INV) |=> saved_q == $past(acc_q))
		else $error("load did not save accumulator");
	a_cnt_mc_off: // RL15
	assert property (@(posedge clk) disable iff (rst)
		instr_valid && instr_op == LIE_OP_CNT && instr_kind == LIE_K_C && !idx_bad && !gate
		|=> !c_coil_q[$past(ci)] && c_val_q[$past(ci)] == $past(c_val_q[ci])
		&& c_done_q[$past(ci)] == $past(c_done_q[ci]))
		else $error("counter changed under control off");
endmodule : lie_executor
`default_nettype wire

// file: lie_defines.svh
// Constants for the ladder instruction executor: sizes, limits, timing.
// Assumes inclusion by bare name from the package and the design files.
// Behaviour
// [RL1] Push copies the accumulator onto the logic stack and bumps the pointer.
// [RL2] Peek loads the top stack entry into the accumulator; pointer unchanged.
// [RL3] Set turns an output or relay on and latches it; only those accepted.
// [RL4] Clear of an output or relay turns its coil and contact off.
// [RL5] Clear of timer or counter zeroes its value, coil and contact.
// [RL6] Clear of a data word writes zero into it.
// [RL7] Latched elements and reached timers hold state until cleared.
// [RL8] Timer instruction energises one of 160 timers; preset constant or data word.
// [RL9] Timer contact closes once elapsed value reaches or passes the preset.
// [RL10] Each rising count input adds one to one of 80 counters.
// [RL11] Counter contact closes when count equals preset.
// [RL12] A reached counter ignores pulses and holds until cleared.
// [RL13] With master control on, enclosed instructions execute normally.
// [RL14] With master control off, enclosed timers reset and de-energise.
// [RL15] With master control off, counters de-energise but keep count and contact.
// [RL16] With master control off, output coils drop and application commands skip.
// [RL17] With master control off, set and clear targets keep their state.
// [RL18] Program places the release at region end with no contact just before.
// [RL19] Master control nests at most eight deep, levels used in ascending order.
// [RL20] Scan runs from address zero to the end marker, then restarts at zero.
// [RL21] Contact load saves the old accumulator and loads the contact state.
// [RL22] Stack overflow or nesting past eight levels raises an error pulse.
`ifndef LIE_DEFINES_SVH
`define LIE_DEFINES_SVH
`define LIE_X_N 16
`define LIE_Y_N 16
`define LIE_M_N 800
`define LIE_T_N 160
`define LIE_C_N 80
`define LIE_D_N 400
`define LIE_STK_DEPTH 8
`define LIE_MC_LEVELS 8
`define LIE_KMAX 16'h7FFF
`define LIE_ADDR_W 12
`define LIE_TICK_MS 100
`define LIE_CLK_KHZ 40000
`endif

// file: lie_pkg.sv
// Types shared by the executor and its accumulator stack.
// Assumes lie_defines.svh is reachable by bare name.
`include "lie_defines.svh"
package lie_pkg;
	typedef enum logic [3:0] {LIE_OP_NOP, LIE_OP_LOAD, LIE_OP_LOAD_INV, LIE_OP_OUT, LIE_OP_SET, LIE_OP_RST,
		LIE_OP_PUSH, LIE_OP_PEEK, LIE_OP_POP, LIE_OP_TMR, LIE_OP_CNT, LIE_OP_MC, LIE_OP_MCR, LIE_OP_APP,
		LIE_OP_END} lie_op_t;
	typedef enum logic [2:0] {LIE_K_X, LIE_K_Y, LIE_K_M, LIE_K_T, LIE_K_C, LIE_K_D} lie_kind_t;
endpackage : lie_pkg

// file: lie_acc_stack.sv
// One-bit logic stack behind the accumulator: push, peek, pop.
// Assumes at most one of push, peek, pop per cycle.
`timescale 1ns/100ps
`default_nettype none
`include "lie_defines.svh"
module lie_acc_stack
	import lie_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic peek,
	input wire logic pop,
	input wire logic din,
	output logic dout,
	output logic err
);
	logic [`LIE_STK_DEPTH-1:0] mem_q;
	logic [3:0] ptr_q;
	logic full;
	logic empty;

	assign full = (ptr_q == 4'(`LIE_STK_DEPTH));
	assign empty = (ptr_q == 4'h0);
	assign dout = empty ? 1'b0 : mem_q[3'(ptr_q - 4'h1)];
	assign err = (push && full) || ((peek || pop) && empty);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mem_q <= '0;
		else if (push && !full)
			mem_q[3'(ptr_q)] <= din; // RL1
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ptr_q <= 4'h0;
		else if (push && !full)
			ptr_q <= ptr_q + 4'h1; // RL1
		else if (pop && !empty)
			ptr_q <= ptr_q - 4'h1;
	end

	a_push_ptr: // RL1
	assert property (@(posedge clk) disable iff (rst)
		push && !full |=> ptr_q == $past(ptr_q) + 4'h1 && mem_q[3'($past(ptr_q))] == $past(din))
		else $error("push did not store and advance");
	a_peek_ptr: // RL2
	assert property (@(posedge clk) disable iff (rst) peek |=> $stable(ptr_q))
		else $error("peek moved the stack pointer");
endmodule : lie_acc_stack
`default_nettype wire

// file: lie_executor_tb.sv
// Self-checking bench for the ladder executor, compared step by step with an in-bench model.
// Assumes lie_pkg and lie_defines.svh are compiled ahead of this file.
`timescale 1ns/100ps
`default_nettype none
module lie_executor_tb
	import lie_pkg::*;
;
	// ----------------------------------------
	// Clock, stimulus and design
	// ----------------------------------------
	localparam int TK = 4;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	lie_op_t instr_op = LIE_OP_NOP;
	lie_kind_t instr_kind = LIE_K_X;
	logic [9:0] instr_index = 10'h000;
	logic [15:0] instr_k = 16'h0000;
	logic instr_pre_d = 1'b0;
	logic [8:0] instr_pre_idx = 9'h005;
	logic [2:0] instr_level = 3'h0;
	logic [15:0] x_in = 16'h0000;
	logic dw_en = 1'b0;
	logic [8:0] dw_idx = 9'h000;
	logic [15:0] dw_data = 16'h0000;
	logic [11:0] prog_addr;
	logic acc, app_fire, scan_done, err;
	logic [15:0] y_out;
	int fails = 0;
	int check_count = 0;
	always #12.5 clk = ~clk;
	lie_executor #(.TICK_CYCLES(TK)) u_dut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
		.instr_kind(instr_kind), .instr_index(instr_index), .instr_k(instr_k), .instr_pre_d(instr_pre_d),
		.instr_pre_idx(instr_pre_idx), .instr_level(instr_level), .x_in(x_in), .dw_en(dw_en), .dw_idx(dw_idx),
		.dw_data(dw_data), .prog_addr(prog_addr), .acc(acc), .y_out(y_out), .app_fire(app_fire),
		.scan_done(scan_done), .err(err));
	// ----------------------------------------
	// Reference model state
	// ----------------------------------------
	logic ma = 1'b0, me = 1'b0, mf = 1'b0, msd = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [15:0] ym = 16'h0000, xv = 16'h0000;
	logic [799:0] mm = '0;
	int tn[160], tp[160], cv[80], cpre[80], d5 = 0;
	bit cp[80];
	bit pd = 1'b0;
	logic stk[$], mcq[$];
	logic [31:0] rs = 32'h000139DA;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk
	task automatic results();
		$display("comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	// Contact as read back by a load; timers only read well clear of the tick jitter
	function automatic logic cont(input lie_kind_t kd, input int ix);
		case (kd)
			LIE_K_X: return xv[ix];
			LIE_K_Y: return ym[ix];
			LIE_K_M: return mm[ix];
			LIE_K_T: return tn[ix] >= TK * (tp[ix] + 2);
			LIE_K_C: return cv[ix] == cpre[ix];
			default: return 1'b0;
		endcase
	endfunction : cont
	// ----------------------------------------
	// One instruction: drive, compare the previous result, advance the model
	// ----------------------------------------
	task automatic ex(input lie_op_t op, input lie_kind_t kd, input int ix, input int k);
		logic g;
		logic r;
		int p;
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_kind <= kd;
		instr_index <= ix[9:0];
		instr_k <= k[15:0];
		instr_level <= k[2:0];
		instr_pre_d <= pd;
		x_in <= xv;
		dw_en <= 1'b0;
		#1;
		chk(16'(acc), 16'(ma), "acc");
		chk(y_out, ym, "y_out");
		chk(16'(prog_addr), 16'(pa), "prog_addr");
		chk(16'(err), 16'(me), "err");
		chk(16'(app_fire), 16'(mf), "app_fire");
		chk(16'(scan_done), 16'(msd), "scan_done");
		g = 1'b1;
		foreach (mcq[j])
			g &= mcq[j];
		p = pd ? d5 : k;
		me = 1'b0;
		mf = 1'b0;
		msd = 1'b0;
		pa = pa + 12'h001;
		case (op)
			LIE_OP_LOAD: ma = cont(kd, ix);
			LIE_OP_LOAD_INV: ma = !cont(kd, ix);
			LIE_OP_OUT: if (kd == LIE_K_Y) ym[ix] = ma & g;
				else if (kd == LIE_K_M) mm[ix] = ma & g;
			LIE_OP_SET: if (kd != LIE_K_Y && kd != LIE_K_M) me = 1'b1;
				else if (ma & g && kd == LIE_K_Y) ym[ix] = 1'b1;
				else if (ma & g) mm[ix] = 1'b1;
			LIE_OP_RST: if (ma & g)
			begin
				case (kd)
					LIE_K_Y: ym[ix] = 1'b0;
					LIE_K_M: mm[ix] = 1'b0;
					LIE_K_T: tn[ix] = 0;
					LIE_K_C: begin cv[ix] = 0; cp[ix] = 1'b0; end
					LIE_K_D: d5 = 0;
					default: ;
				endcase
			end
			LIE_OP_PUSH: if (stk.size() == 8) me = 1'b1; else stk.push_back(ma);
			LIE_OP_PEEK: if (stk.size() == 0) begin ma = 1'b0; me = 1'b1; end else ma = stk[$];
			LIE_OP_POP: if (stk.size() == 0) begin ma = 1'b0; me = 1'b1; end else ma = stk.pop_back();
			LIE_OP_TMR: begin tp[ix] = p; if (!g) tn[ix] = 0; else if (ma) tn[ix]++; end
			LIE_OP_CNT:
			begin
				r = ma & g;
				if (r && !cp[ix] && cv[ix] < p) cv[ix]++;
				cp[ix] = r;
				cpre[ix] = p;
			end
			LIE_OP_MC: if (k != mcq.size()) me = 1'b1; else mcq.push_back(ma);
			LIE_OP_MCR: while (mcq.size() > k) void'(mcq.pop_back());
			LIE_OP_APP: mf = ma & g;
			LIE_OP_END: begin ma = 1'b0; pa = 12'h000; msd = 1'b1; mcq.delete(); end
			default: ;
		endcase
	endtask : ex
	task automatic dw(input int v);
		@(posedge clk);
		instr_valid <= 1'b0;
		dw_en <= 1'b1;
		dw_idx <= 9'h005;
		dw_data <= v[15:0];
		d5 = v;
		me = 1'b0;
		mf = 1'b0;
		msd = 1'b0;
	endtask : dw
	task automatic fin(input string n);
		$display("test %s finished", n);
	endtask : fin
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		#(25 * 20000);
		fails++;
		results();
	end
	initial
	begin
		lie_kind_t bad[4];
		bad = '{LIE_K_X, LIE_K_T, LIE_K_C, LIE_K_D};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			rs = lfsr(rs);
			xv = rs[15:0];
			ex(rs[24] ? LIE_OP_LOAD : LIE_OP_LOAD_INV, LIE_K_X, int'(rs[19:16]), 0);
			ex(LIE_OP_OUT, LIE_K_Y, int'(rs[23:20]), 0);
		end
		fin("random load and drive");
		for (int i = 0; i < 9; i++)
		begin
			xv = 16'(i & 1);
			ex(LIE_OP_LOAD, LIE_K_X, 0, 0);
			ex(LIE_OP_PUSH, LIE_K_X, 0, 0);
		end
		ex(LIE_OP_PEEK, LIE_K_X, 0, 0);
		ex(LIE_OP_PEEK, LIE_K_X, 0, 0);
		repeat (9) ex(LIE_OP_POP, LIE_K_X, 0, 0);
		ex(LIE_OP_PEEK, LIE_K_X, 0, 0);
		fin("logic stack");
		xv = 16'h0001;
		ex(LIE_OP_LOAD, LIE_K_X, 0, 0);
		ex(LIE_OP_SET, LIE_K_Y, 6, 0);
		ex(LIE_OP_SET, LIE_K_Y, 3, 0);
		ex(LIE_OP_SET, LIE_K_M, 5, 0);
		foreach (bad[j])
			ex(LIE_OP_SET, bad[j], 2, 0);
		ex(LIE_OP_LOAD, LIE_K_M, 5, 0);
		ex(LIE_OP_LOAD_INV, LIE_K_X, 0, 0);
		ex(LIE_OP_SET, LIE_K_Y, 6, 0);
		ex(LIE_OP_RST, LIE_K_Y, 3, 0);
		ex(LIE_OP_LOAD, LIE_K_X, 0, 0);
		ex(LIE_OP_RST, LIE_K_Y, 3, 0);
		ex(LIE_OP_RST, LIE_K_M, 5, 0);
		ex(LIE_OP_LOAD, LIE_K_M, 5, 0);
		fin("set and clear");
		ex(LIE_OP_LOAD, LIE_K_X, 0, 0);
		repeat (16) ex(LIE_OP_TMR, LIE_K_T, 9, 2);
		ex(LIE_OP_LOAD_INV, LIE_K_X, 0, 0);
		ex(LIE_OP_TMR, LIE_K_T, 9, 2);
		ex(LIE_OP_LOAD, LIE_K_T, 9, 0);
		ex(LIE_OP_RST, LIE_K_T, 9, 0);
		ex(LIE_OP_LOAD, LIE_K_T, 9, 0);
		ex(LIE_OP_LOAD, LIE_K_X, 0, 0);
		ex(LIE_OP_RST, LIE_K_T, 9, 0);
		ex(LIE_OP_LOAD, LIE_K_T, 9, 0);
		fin("timer");
		dw(3);
		pd = 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			xv = 16'(~i & 1);
			ex(LIE_OP_LOAD, LIE_K_X, 0, 0);
			ex(LIE_OP_CNT, LIE_K_C, 7, 0);
			ex(LIE_OP_LOAD, LIE_K_C, 7, 0);
		end
		xv = 16'h0001;
		ex(LIE_OP_LOAD, LIE_K_X, 0, 0);
		ex(LIE_OP_RST, LIE_K_C, 7, 0);
		ex(LIE_OP_RST, LIE_K_D, 5, 0);
		ex(LIE_OP_CNT, LIE_K_C, 8, 0);
		ex(LIE_OP_LOAD, LIE_K_C, 8, 0);
		ex(LIE_OP_LOAD, LIE_K_C, 7, 0);
		pd = 1'b0;
		fin("counter");
		ex(LIE_OP_LOAD, LIE_K_X, 0, 0);
		repeat (16) ex(LIE_OP_TMR, LIE_K_T, 9, 2);
		xv = 16'h0002;
		ex(LIE_OP_LOAD, LIE_K_X, 1, 0);
		ex(LIE_OP_MC, LIE_K_X, 0, 0);
		ex(LIE_OP_LOAD, LIE_K_X, 2, 0);
		ex(LIE_OP_MC, LIE_K_X, 0, 1);
		ex(LIE_OP_LOAD, LIE_K_X, 1, 0);
		ex(LIE_OP_OUT, LIE_K_Y, 4, 0);
		ex(LIE_OP_RST, LIE_K_Y, 6, 0);
		ex(LIE_OP_SET, LIE_K_Y, 3, 0);
		ex(LIE_OP_APP, LIE_K_X, 0, 0);
		ex(LIE_OP_TMR, LIE_K_T, 9, 2);
		ex(LIE_OP_CNT, LIE_K_C, 7, 3);
		ex(LIE_OP_MCR, LIE_K_X, 0, 1);
		ex(LIE_OP_LOAD, LIE_K_T, 9, 0);
		ex(LIE_OP_LOAD, LIE_K_X, 1, 0);
		ex(LIE_OP_OUT, LIE_K_Y, 4, 0);
		ex(LIE_OP_APP, LIE_K_X, 0, 0);
		ex(LIE_OP_MC, LIE_K_X, 0, 3);
		ex(LIE_OP_MCR, LIE_K_X, 0, 0);
		for (int l = 0; l < 8; l++)
			ex(LIE_OP_MC, LIE_K_X, 0, l);
		ex(LIE_OP_MC, LIE_K_X, 0, 7);
		ex(LIE_OP_APP, LIE_K_X, 0, 0);
		ex(LIE_OP_END, LIE_K_X, 0, 0);
		ex(LIE_OP_NOP, LIE_K_X, 0, 0);
		ex(LIE_OP_NOP, LIE_K_X, 0, 0);
		fin("master control and end");
		results();
	end
endmodule : lie_executor_tb
`default_nettype wire
